/* verilog/nav_mod_pkg.sv */
// Purpose: Shared constants for the modulating sequence generator
// Assumes: 20 MHz reference clock, chip timing derived by phase accumulator
// Notes:   Times are kept in their own units; cycle counts derive from them
package nav_mod_pkg;

  // ----------------------------------------------------------------------
  // Clock and chip timing
  // ----------------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ     = 20_000_000;
  localparam int unsigned CHIP_RATE_BPS  = 511_000;
  localparam int unsigned CODE_PERIOD_US = 1000;
  localparam int unsigned CHIPS_PER_CODE = CHIP_RATE_BPS * CODE_PERIOD_US / 1_000_000;
  localparam int unsigned LFSR_W         = 9;
  localparam int unsigned LFSR_OUT_BIT   = 6;
  localparam int unsigned LFSR_TAP_A     = 4;
  localparam int unsigned LFSR_TAP_B     = 8;
  localparam logic [8:0]  LFSR_INIT      = 9'h1ff;

  // ----------------------------------------------------------------------
  // Message timing
  // ----------------------------------------------------------------------
  localparam int unsigned SLOT_MS        = 10;
  localparam int unsigned DATA_BIT_MS    = 20;
  localparam int unsigned STRING_MS      = 2000;
  localparam int unsigned DATA_PART_MS   = 1700;
  localparam int unsigned TMARK_PART_MS  = 300;
  localparam int unsigned DATA_BITS      = DATA_PART_MS / DATA_BIT_MS;
  localparam int unsigned SLOTS_PER_STR  = STRING_MS / SLOT_MS;
  localparam int unsigned DATA_SLOTS     = DATA_PART_MS / SLOT_MS;
  localparam int unsigned TMARK_BITS     = TMARK_PART_MS / SLOT_MS;
  localparam int unsigned EPOCHS_PER_SLOT = SLOT_MS * 1000 / CODE_PERIOD_US;
  localparam logic [29:0] TMARK_PATTERN  = 30'h3e375096;

  // ----------------------------------------------------------------------
  // Time scale
  // ----------------------------------------------------------------------
  localparam int unsigned TOD_OFFSET_S   = 3 * 3600;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic        MOD_RST        = 1'b1;

endpackage : nav_mod_pkg

/* verilog/pin_sync2.sv */
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are levels from outside the clock domain
// Notes:   Only the second stage is read by other logic
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : pin_sync2
`default_nettype wire

/* verilog/nav_signal_modulating_sequence_gen.sv */
// Purpose: Modulating bit train: ranging code xor message xor meander
// Assumes: String words arrive Hamming coded; second pulses from onboard scale
// Notes:   Chip timing uses a 511/20000 phase accumulator on the 20 MHz clock
//
// Function
// - Output is xor of ranging code, 50 bps message and 100 Hz meander.
// - Maximal-length code at 511 kbps, period exactly one millisecond.
// - Ranging chip taken from stage seven of nine-stage register.
// - Register loaded with all ones at start of every code period.
// - Each millisecond starts with the first chip of the run 111111100.
// - Feedback implements 1 + x^5 + x^9.
// - Two-second strings; first 1.7 s carry 85 data bits.
// - Last 0.3 s of each string carries the time mark.
// - Data bits relative coded, 20 ms, xored with 10 ms meander bits.
// - Time mark is fixed 30-bit pattern, 10 ms per bit.
// - First data bit of every string is always zero.
// - All boundaries synchronous; bit boundaries on code epoch start.
// - Last time-mark bit ends at even second of day.
// - Leap-second re-enumeration moves strings to new two-second epochs.
// - Onboard day runs three hours ahead of UTC reference.
// - Hamming-coded data converted to relative code before meander.
`timescale 1ns/1ps
`default_nettype none
module nav_signal_modulating_sequence_gen
  import nav_mod_pkg::*;
#(
  parameter int unsigned CLK_HZ  = REF_CLK_HZ,
  parameter int unsigned CHIP_HZ = CHIP_RATE_BPS
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Onboard time scale
  input  wire logic        sec_pulse_i,
  input  wire logic        sec_even_i,
  // String data
  input  wire logic [84:0] string_word_i,
  output logic             string_taken_o,
  // Modulator
  output logic             mod_o,
  output logic             epoch_o
);

  // ----------------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------------
  localparam int unsigned ACC_MOD = CLK_HZ / 1000;
  localparam int unsigned ACC_INC = CHIP_HZ / 1000;
  localparam int unsigned ACC_W   = $clog2(2 * ACC_MOD);

  localparam logic [ACC_W-1:0] ACC_MOD_C  = ACC_W'(ACC_MOD);
  localparam logic [ACC_W-1:0] ACC_INC_C  = ACC_W'(ACC_INC);
  localparam logic [8:0]       CHIP_LAST  = 9'(CHIPS_PER_CODE - 1);
  localparam logic [3:0]       MS_LAST    = 4'(EPOCHS_PER_SLOT - 1);
  localparam logic [7:0]       SLOT_LAST  = 8'(SLOTS_PER_STR - 1);
  localparam logic [7:0]       SLOT_DATA  = 8'(DATA_SLOTS);
  localparam logic [4:0]       TMARK_LAST = 5'(TMARK_BITS - 1);

  // Elaboration check
  if (CLK_HZ % 1000 != 0 || CHIP_HZ % 1000 != 0 || CHIP_HZ > CLK_HZ / 2
      || CHIP_HZ / 1000 != CHIPS_PER_CODE || TOD_OFFSET_S % 2 != 0)
  begin : g_bad_cfg
    $error("nav_signal_modulating_sequence_gen: unsupported clock setup");
  end

  // ----------------------------------------------------------------------
  // Second pulse synchronisation
  // ----------------------------------------------------------------------
  logic [1:0] pin_s;
  logic       pps_prev_q;
  logic       resync;

  pin_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({sec_even_i, sec_pulse_i}),
    .sync_o    (pin_s)
  );

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pps_prev_q <= 1'b0;
    else
      pps_prev_q <= pin_s[0];
  end

  // Even second of the onboard day, leap re-enumeration included
  assign resync = pin_s[0] & ~pps_prev_q & pin_s[1];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic [ACC_W-1:0] acc_q, acc_d, acc_sum;
  logic [8:0]       chip_cnt_q, chip_cnt_d;
  logic [8:0]       lfsr_q, lfsr_d;
  logic [3:0]       ms_q, ms_d;
  logic [7:0]       slot_q, slot_d;
  logic [84:0]      word_q, word_d;
  logic             rel_q, rel_d;
  logic             msg_q, msg_d;
  logic             mod_q;
  logic             tick, epoch_end, slot_end, string_start, next_bit;
  logic [4:0]       tm_idx;

  always_comb
  begin
    acc_sum      = acc_q + ACC_INC_C;
    tick         = acc_sum >= ACC_MOD_C;
    epoch_end    = tick && chip_cnt_q == CHIP_LAST;
    slot_end     = epoch_end && ms_q == MS_LAST;
    string_start = resync || (slot_end && slot_q == SLOT_LAST);
    next_bit     = slot_end && slot_q[0] && slot_q < SLOT_DATA - 8'h01;
    // Fractional chip clock
    acc_d = resync ? '0 : (tick ? acc_sum - ACC_MOD_C : acc_sum);
    chip_cnt_d = (string_start || epoch_end) ? 9'h000 :
                 (tick ? chip_cnt_q + 9'h001 : chip_cnt_q);
    // Epoch reload and feedback 1 + x^5 + x^9
    lfsr_d = (string_start || epoch_end) ? LFSR_INIT :
             (tick ? {lfsr_q[7:0], lfsr_q[LFSR_TAP_A] ^ lfsr_q[LFSR_TAP_B]} : lfsr_q);
    // Slot clocks divided from code epochs
    ms_d   = (string_start || slot_end) ? 4'h0 : (epoch_end ? ms_q + 4'h1 : ms_q);
    slot_d = string_start ? 8'h00 : (slot_end ? slot_q + 8'h01 : slot_q);
    // Idle first bit forced to zero
    word_d = string_start ? {1'b0, string_word_i[83:0]} :
             (next_bit ? {word_q[83:0], 1'b0} : word_q);
    // Relative coding of coded data
    rel_d  = string_start ? 1'b0 : (next_bit ? rel_q ^ word_q[83] : rel_q);
    tm_idx = 5'(slot_d - SLOT_DATA);
    // Data part then time mark
    msg_d  = (slot_d < SLOT_DATA) ? rel_d ^ slot_d[0] : TMARK_PATTERN[TMARK_LAST - tm_idx];
  end

  // ----------------------------------------------------------------------
  // Timing state
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acc_q      <= '0;
      chip_cnt_q <= 9'h000;
      lfsr_q     <= LFSR_INIT;
      ms_q       <= 4'h0;
      slot_q     <= 8'h00;
    end
    else
    begin
      acc_q      <= acc_d;
      chip_cnt_q <= chip_cnt_d;
      lfsr_q     <= lfsr_d;
      ms_q       <= ms_d;
      slot_q     <= slot_d;
    end
  end

  // ----------------------------------------------------------------------
  // Message state
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      word_q         <= '0;
      rel_q          <= 1'b0;
      msg_q          <= 1'b0;
      string_taken_o <= 1'b0;
    end
    else
    begin
      word_q         <= word_d;
      rel_q          <= rel_d;
      msg_q          <= msg_d;
      string_taken_o <= string_start;
    end
  end

  // ----------------------------------------------------------------------
  // Output bit train
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mod_q   <= MOD_RST;
      epoch_o <= 1'b0;
    end
    else
    begin
      mod_q   <= lfsr_d[LFSR_OUT_BIT] ^ msg_d;
      epoch_o <= string_start || epoch_end;
    end
  end

  assign mod_o = mod_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Clocks since last chip tick or restart
  localparam logic [ACC_W-1:0] GAP_MIN = ACC_W'(ACC_MOD / ACC_INC - 1);
  localparam logic [ACC_W-1:0] GAP_MAX = ACC_W'((ACC_MOD + ACC_INC - 1) / ACC_INC - 1);

  logic [ACC_W-1:0] gap_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      gap_q <= '0;
    else
      gap_q <= (tick || resync) ? '0 : gap_q + ACC_W'(1);
  end

  AST_CHIP_SPACING: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    tick |-> gap_q >= GAP_MIN && gap_q <= GAP_MAX)
    else $error("chip ticks off the chip rate");

  AST_CODE_LENGTH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    chip_cnt_q <= CHIP_LAST)
    else $error("chip count past code period");

  AST_EPOCH_RELOAD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    epoch_end |=> lfsr_q == LFSR_INIT && chip_cnt_q == 9'h000)
    else $error("register not reloaded at epoch");

  AST_FEEDBACK: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    tick && !epoch_end && !resync |=>
      lfsr_q == {$past(lfsr_q[7:0]), $past(lfsr_q[4]) ^ $past(lfsr_q[8])})
    else $error("feedback wrong");

  AST_OUT_XOR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ##1 mod_o == (lfsr_q[LFSR_OUT_BIT] ^ msg_q))
    else $error("output not code xor message");

  AST_DATA_MEANDER: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    slot_q < SLOT_DATA |-> msg_q == (rel_q ^ slot_q[0]))
    else $error("data part not data xor meander");

  AST_TMARK: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    slot_q >= SLOT_DATA |-> msg_q == TMARK_PATTERN[TMARK_LAST - 5'(slot_q - SLOT_DATA)])
    else $error("time mark bit wrong");

  AST_IDLE_BIT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    string_start |=> rel_q == 1'b0 && slot_q == 8'h00 && string_taken_o)
    else $error("string did not open with idle bit");

  AST_RESYNC: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    resync |=> chip_cnt_q == 9'h000 && ms_q == 4'h0 && lfsr_q == LFSR_INIT)
    else $error("even second did not restart string");

  AST_BOUNDARY: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $changed(slot_q) |-> chip_cnt_q == 9'h000 && ms_q == 4'h0)
    else $error("bit boundary off code epoch");

endmodule : nav_signal_modulating_sequence_gen
`default_nettype wire

/* tb/nav_rx_model.sv */
// Purpose: Receiver side model capturing one code period of the train
// Assumes: Chip period is a whole number of clocks after each epoch pulse
// Notes:   Publishes the previous period at every epoch pulse
`timescale 1ns/1ps
`default_nettype none
module nav_rx_model #(
  parameter int unsigned CPC = 2
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  // Modulated train
  input  wire logic         mod_i,
  input  wire logic         epoch_i,
  // Captured period
  output logic      [510:0] chips_o,
  output logic              frame_o
);
  // ----------------------------------------------------------------------
  // Chip capture, mid-chip sampling
  // ----------------------------------------------------------------------
  int unsigned  cyc_q;
  logic [510:0] buf_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cyc_q   <= 0;
      buf_q   <= '0;
      chips_o <= '0;
      frame_o <= 1'b0;
    end
    else
    begin
      frame_o <= epoch_i;
      if (epoch_i)
      begin
        chips_o <= buf_q;
        cyc_q   <= 1;
      end
      else
      begin
        cyc_q <= cyc_q + 1;
        if (cyc_q % CPC == CPC / 2 && cyc_q / CPC < 511)
          buf_q[cyc_q / CPC] <= mod_i;
      end
    end
  end
endmodule : nav_rx_model
`default_nettype wire

/* tb/nav_signal_modulating_sequence_gen_tb.sv */
// Purpose: Self-checking bench for the modulating sequence generator
// Assumes: Clock scaled to two clocks per chip
// Notes:   Covers reset, epoch period, refused pulse and string start
`timescale 1ns/1ps
`default_nettype none
module nav_signal_modulating_sequence_gen_tb;
  import nav_mod_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_T = 1_022_000;
  localparam int unsigned EP    = CLK_T / 1000;
  logic         ref_clk_i;
  logic         resetn_i;
  logic         sec_pulse_i;
  logic         sec_even_i;
  logic [84:0]  string_word_i;
  logic         string_taken_o;
  logic         mod_o;
  logic         epoch_o;
  logic [510:0] chips;
  logic         frame;
  int           n_fail;
  int           samples_checked;

  nav_signal_modulating_sequence_gen #(.CLK_HZ(CLK_T), .CHIP_HZ(CHIP_RATE_BPS))
    u_nav_signal_modulating_sequence_gen (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .sec_pulse_i(sec_pulse_i), .sec_even_i(sec_even_i), .string_word_i(string_word_i),
    .string_taken_o(string_taken_o), .mod_o(mod_o), .epoch_o(epoch_o));
  nav_rx_model #(.CPC(2)) u_nav_rx_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .mod_i(mod_o), .epoch_i(epoch_o), .chips_o(chips), .frame_o(frame));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [510:0] seen, input logic [510:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic wait_high(input bit use_frame);
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    while ((use_frame ? frame : epoch_o) !== 1'b1 && k < 3 * EP);
    if (k >= 3 * EP)
    begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_high

  function automatic logic [510:0] ref_code();
    logic [8:0]   s;
    logic [510:0] c;
    s = 9'h1ff;
    for (int n = 0; n < 511; n++)
    begin
      c[n] = s[6];
      s = {s[7:0], s[4] ^ s[8]};
    end
    return c;
  endfunction : ref_code

  // Pulse the second input, count string starts seen
  task automatic pulse_sec(input logic ev, output int hits);
    hits = 0;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge ref_clk_i);
      sec_pulse_i <= (i < 3);
      sec_even_i  <= ev;
      #1;
      if (string_taken_o === 1'b1)
        hits++;
    end
  endtask : pulse_sec
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_epoch_period();
    int k;
    wait_high(1'b0);
    k = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    while (epoch_o !== 1'b1 && k < 2 * EP);
    check("epoch spacing", k, EP);
  endtask : s_epoch_period

  task automatic s_odd_pulse();
    int hits;
    pulse_sec(1'b0, hits);
    check("odd pulse starts", hits, 0);
  endtask : s_odd_pulse

  task automatic s_string();
    int           hits;
    logic [3:0]   rel;
    logic [510:0] code;
    int           slot;
    code = ref_code();
    rel  = 4'b0110;
    @(posedge ref_clk_i);
    string_word_i <= {4'hd, 81'h0};
    pulse_sec(1'b1, hits);
    check("even pulse starts", hits, 1);
    for (int e = 0; e < 80; e++)
    begin
      wait_high(1'b1);
      slot = e / 10;
      check("epoch chips", chips, code ^ {511{rel[slot / 2] ^ slot[0]}});
    end
  endtask : s_string
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    n_fail          = 0;
    samples_checked = 0;
    resetn_i        = 1'b0;
    sec_pulse_i     = 1'b0;
    sec_even_i      = 1'b0;
    string_word_i   = '0;
    repeat (8) @(posedge ref_clk_i);
    #1;
    check("reset mod", mod_o, 1'b1);
    check("reset epoch", epoch_o, 1'b0);
    check("reset taken", string_taken_o, 1'b0);
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    s_epoch_period();
    s_odd_pulse();
    s_string();
    wrap_up();
  end
endmodule : nav_signal_modulating_sequence_gen_tb
`default_nettype wire
